/* hdl/flash_iap_control.sv */
/*
  Flash in-application programming control: control register, data word registers,
  unlock timer, operation sequencer and CPU stall.
  Assumes the CPU issues register accesses on the sfr port synchronous to mclk and
  that the flash array answers each command with a one-cycle flash_done pulse.
  Assumes the flash array raises flash_done only in answer to a request, one cycle or
  more after it, and that the write buffer itself and its clear control live outside.
  The unlock timer counts mclk edges, so UNLOCK_CYCLES must follow the clock rate.
*/
// Behaviour
// RULE1 - The fourth data word high byte is a full eight-bit read/write register used for unlock and data.
// RULE2 - Software writing one to the erase/write enabled status bit has no effect.
// RULE3 - Software writing zero to that status bit clears it and disables erase and write at once; a same-write initiate still starts, a set at expiry wins.
// RULE4 - Only hardware sets the status bit, and only after a successful enable procedure.
// RULE5 - The mode field decodes 000 write, 001 page erase, 011 read, 110 enable, all others reserved.
// RULE6 - Software must finish the enable procedure before asking for an erase or a write.
// RULE7 - Setting the unlock trigger starts a 1 ms timer and hardware clears the trigger when it expires.
// RULE8 - Software must write the unlock pattern into data words two to four before the timer expires.
// RULE9 - Setting write initiate starts a write and hardware clears the bit when the write completes.
// RULE10 - While write or read initiate is set the CPU is stalled.
// RULE11 - Reads are refused while read enable is zero.
// RULE12 - Setting read initiate starts a read and hardware clears the bit when the read completes.
// RULE13 - Software must not set write initiate, read enable and read initiate in one write.
// RULE14 - The unlock pattern is 00, 0d, c3 in the low bytes and 04, 09, 40 in the high bytes of words two to four.
// RULE15 - At timer expiry the trigger always clears and the status bit sets only on a correct pattern.
// RULE16 - Writing the first data word high byte loads the whole first word into the write buffer and bumps the address.
// RULE17 - A reserved mode makes the initiate bits clear with no flash operation.
`timescale 1ns/1ps
module flash_iap_control
  import flash_ctl_pkg::*;
#(
  parameter logic [CNT_W-1:0] UNLOCK_CYCLES = CNT_W'(UNLOCK_CYCLES_DEF)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire sfr_req_t sfr,
  output logic [7:0] sfr_rdata,
  output logic cpu_stall,
  output flash_cmd_t flash_cmd,
  input wire logic flash_done,
  input wire logic [15:0] flash_rdata,
  output logic buffer_load,
  output logic [15:0] buffer_word
);

  ctl_state_t cur;
  ctl_state_t next_state;
  logic [3:0] low_sel;
  logic [3:0] high_sel;
  logic [3:0] word_match;

  localparam logic [3:0][7:0] PAT_LOW = {PAT_D3_LOW, PAT_D2_LOW, PAT_D1_LOW, 8'h00};
  localparam logic [3:0][7:0] PAT_HIGH = {PAT_D3_HIGH, PAT_D2_HIGH, PAT_D1_HIGH, 8'h00};

  // Every output is a flop of the state, so the CPU never sees a decode glitch on the stall.
  assign sfr_rdata = cur.rdata;
  assign cpu_stall = cur.stall;
  assign flash_cmd = cur.cmd;
  assign buffer_load = cur.buf_load;
  assign buffer_word = cur.buf_word;

  // One copy per data word: select decode, and for words two to four the unlock pattern compare.
  for (genvar w = 0; w < 4; w++) begin : g_word
    localparam logic [3:0] SEL_LOW = SEL_DATA_FIRST + 4'(2 * w);
    localparam logic [3:0] SEL_HIGH = SEL_DATA_FIRST + 4'(2 * w + 1);
    assign low_sel[w] = (sfr.sel == SEL_LOW);
    assign high_sel[w] = (sfr.sel == SEL_HIGH);
    if (w == 0) begin : g_plain
      // The first word carries transfer data only and takes no part in the unlock compare.
      assign word_match[w] = 1'b1;
    end else begin : g_pattern
      assign word_match[w] = (cur.dlow[w] == PAT_LOW[w]) && (cur.dhigh[w] == PAT_HIGH[w]); // [RULE14]
    end
  end

  always_comb begin
    logic [2:0] wmode;
    logic pattern_ok;
    logic op_legal;
    logic write_legal;
    logic read_legal;
    logic both_initiates;
    logic timer_done;
    next_state = cur;
    wmode = sfr.wdata[BIT_MODE_HI:BIT_MODE_LO];
    pattern_ok = &word_match; // [RULE14]
    // Erase and write need the enable procedure done first. [RULE6]
    write_legal = cur.enabled && (wmode == MODE_WRITE || wmode == MODE_ERASE); // [RULE5]
    // Read enable is taken from the stored bit, so it must be set by an earlier write.
    read_legal = cur.read_en && (wmode == MODE_READ); // [RULE11] [RULE5]
    both_initiates = sfr.wdata[BIT_WRITE] && sfr.wdata[BIT_READ];
    // The count starts from zero on the trigger write, so expiry falls UNLOCK_CYCLES edges later.
    timer_done = (cur.unlock_cnt == UNLOCK_CYCLES - CNT_W'(1));
    op_legal = 1'b0;

    next_state.cmd.req = 1'b0;
    next_state.buf_load = 1'b0;

    if (sfr.rd) begin
      case (sfr.sel)
        SEL_ADDR_LOW: next_state.rdata = cur.addr[7:0];
        SEL_ADDR_HIGH: next_state.rdata = {1'b0, cur.addr[ADDR_W-1:8]};
        SEL_CTRL: next_state.rdata = {cur.enabled, cur.mode, cur.trigger, cur.write_go, cur.read_en, cur.read_go};
        default: begin
          next_state.rdata = 8'h00;
          for (int w = 0; w < 4; w++) begin
            if (low_sel[w]) begin
              next_state.rdata = cur.dlow[w];
            end
            if (high_sel[w]) begin
              next_state.rdata = cur.dhigh[w];
            end
          end
        end
      endcase
    end

    if (sfr.wr) begin
      case (sfr.sel)
        SEL_ADDR_LOW: next_state.addr[7:0] = sfr.wdata;
        SEL_ADDR_HIGH: next_state.addr[ADDR_W-1:8] = sfr.wdata[ADDR_W-9:0];
        SEL_CTRL: begin
          next_state.mode = wmode;
          next_state.read_en = sfr.wdata[BIT_READ_EN];
          // Software can only drop the enable, so a stray write cannot arm erase or write.
          if (!sfr.wdata[BIT_ENABLED]) begin
            next_state.enabled = 1'b0; // [RULE2] [RULE3]
          end
          if (cur.fsm == ST_IDLE) begin
            // Two initiates in one write are taken as a software fault and start nothing.
            if (both_initiates) begin
              op_legal = 1'b0; // [RULE13]
            end else if (sfr.wdata[BIT_TRIGGER]) begin
              next_state.trigger = 1'b1; // [RULE7]
              next_state.unlock_cnt = '0;
              next_state.fsm = ST_UNLOCK;
            end else if (sfr.wdata[BIT_WRITE]) begin
              next_state.write_go = 1'b1; // [RULE9]
              next_state.stall = 1'b1; // [RULE10]
              op_legal = write_legal;
              next_state.cmd.op = (wmode == MODE_ERASE) ? OP_ERASE : OP_WRITE;
              next_state.cmd.req = op_legal;
              next_state.cmd.addr = cur.addr;
              next_state.fsm = op_legal ? ST_BUSY : ST_ABORT; // [RULE17]
            end else if (sfr.wdata[BIT_READ]) begin
              next_state.read_go = 1'b1; // [RULE12]
              next_state.stall = 1'b1; // [RULE10]
              op_legal = read_legal;
              next_state.cmd.op = OP_READ;
              next_state.cmd.req = op_legal;
              next_state.cmd.addr = cur.addr;
              next_state.fsm = op_legal ? ST_BUSY : ST_ABORT; // [RULE17]
            end
          end
        end
        default: begin
          for (int w = 0; w < 4; w++) begin
            if (low_sel[w]) begin
              next_state.dlow[w] = sfr.wdata;
            end
            if (high_sel[w]) begin
              next_state.dhigh[w] = sfr.wdata; // [RULE1]
            end
          end
          if (sfr.sel == SEL_DATA0_HIGH) begin
            // The address moves on with every load so software can stream words without rewriting it.
            next_state.buf_load = 1'b1; // [RULE16]
            next_state.buf_word = {sfr.wdata, cur.dlow[0]};
            next_state.addr = cur.addr + ADDR_W'(1);
          end
        end
      endcase
    end

    // Hardware updates come last so that a hardware set beats a software clear in the same cycle.
    case (cur.fsm)
      ST_IDLE: begin
      end
      ST_UNLOCK: begin
        next_state.unlock_cnt = cur.unlock_cnt + CNT_W'(1);
        if (timer_done) begin
          // The trigger drops at expiry whatever was written; only a full pattern in enable mode arms.
          next_state.trigger = 1'b0; // [RULE7] [RULE15]
          if (pattern_ok && cur.mode == MODE_UNLOCK) begin
            next_state.enabled = 1'b1; // [RULE4] [RULE15] [RULE8]
          end
          next_state.fsm = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (flash_done) begin
          if (cur.read_go) begin
            // Read data lands in the first word, where software also stages write data.
            next_state.dlow[0] = flash_rdata[7:0];
            next_state.dhigh[0] = flash_rdata[15:8];
          end
          next_state.write_go = 1'b0; // [RULE9]
          next_state.read_go = 1'b0; // [RULE12]
          next_state.stall = 1'b0; // [RULE10]
          next_state.fsm = ST_IDLE;
        end
      end
      ST_ABORT: begin
        // A refused request still shows its initiate bit and the stall for one cycle.
        next_state.write_go = 1'b0; // [RULE17]
        next_state.read_go = 1'b0;
        next_state.stall = 1'b0;
        next_state.fsm = ST_IDLE;
      end
      default: next_state.fsm = ST_IDLE;
    endcase
  end

  // One register stage for the whole state keeps every output a flop and the reset a single constant.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_state;
    end
  end

endmodule

/* inc/flash_ctl_pkg.sv */
/*
  Constants, carrier structs and state type for the flash in-application
  programming control block.
  Assumes a single 25 MHz system clock and an 8-bit special function register port.
*/
package flash_ctl_pkg;

  localparam logic [3:0] SEL_ADDR_LOW = 4'h0;
  localparam logic [3:0] SEL_ADDR_HIGH = 4'h1;
  localparam logic [3:0] SEL_DATA_FIRST = 4'h2;
  localparam logic [3:0] SEL_DATA0_HIGH = 4'h3;
  localparam logic [3:0] SEL_DATA_LAST = 4'h9;
  localparam logic [3:0] SEL_CTRL = 4'ha;

  localparam int BIT_ENABLED = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_TRIGGER = 3;
  localparam int BIT_WRITE = 2;
  localparam int BIT_READ_EN = 1;
  localparam int BIT_READ = 0;

  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  localparam logic [7:0] PAT_D1_LOW = 8'h00;
  localparam logic [7:0] PAT_D2_LOW = 8'h0d;
  localparam logic [7:0] PAT_D3_LOW = 8'hc3;
  localparam logic [7:0] PAT_D1_HIGH = 8'h04;
  localparam logic [7:0] PAT_D2_HIGH = 8'h09;
  localparam logic [7:0] PAT_D3_HIGH = 8'h40;

  localparam int ADDR_W = 15;
  localparam int CNT_W = 16;
  localparam int MCLK_PERIOD_NS = 40;
  localparam int UNLOCK_TIME_NS = 1000000;
  localparam int UNLOCK_CYCLES_DEF = UNLOCK_TIME_NS / MCLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_ERASE = 2'h1,
    OP_READ = 2'h2
  } flash_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_UNLOCK = 4'b0010,
    ST_BUSY = 4'b0100,
    ST_ABORT = 4'b1000
  } fsm_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic req;
    flash_op_t op;
    logic [ADDR_W-1:0] addr;
  } flash_cmd_t;

  typedef struct packed {
    fsm_t fsm;
    logic enabled;
    logic [2:0] mode;
    logic trigger;
    logic write_go;
    logic read_en;
    logic read_go;
    logic [CNT_W-1:0] unlock_cnt;
    logic [3:0][7:0] dlow;
    logic [3:0][7:0] dhigh;
    logic [ADDR_W-1:0] addr;
    logic [7:0] rdata;
    logic stall;
    flash_cmd_t cmd;
    logic buf_load;
    logic [15:0] buf_word;
  } ctl_state_t;

  localparam ctl_state_t STATE_RESET = '{fsm: ST_IDLE, cmd: '{req: 1'b0, op: OP_WRITE, addr: '0}, default: '0};

endpackage

/* test/flash_ctl_checker.sv */
/*
  Port assertions for the flash control block.
  Assumes it is bound onto flash_iap_control and sees only its ports.
*/
`timescale 1ns/1ps
module flash_ctl_checker
  import flash_ctl_pkg::*;
#(
  parameter logic [CNT_W-1:0] UNLOCK_CYCLES = 16'h0014
) (
  input wire logic mclk,
  input wire logic reset,
  input wire sfr_req_t sfr,
  input wire logic [7:0] sfr_rdata,
  input wire logic cpu_stall,
  input wire flash_cmd_t flash_cmd,
  input wire logic flash_done,
  input wire logic [15:0] flash_rdata,
  input wire logic buffer_load,
  input wire logic [15:0] buffer_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic ld = sfr.wr && sfr.sel == SEL_DATA0_HIGH;
  wire logic cw = sfr.wr && sfr.sel == SEL_CTRL;
  buffer_fill_a: assert property (ld |=> buffer_load && buffer_word[15:8] == $past(sfr.wdata))
    else $error("buffer load missing");
  load_cause_a: assert property (buffer_load |-> $past(ld))
    else $error("buffer load without cause");
  req_pulse_a: assert property (flash_cmd.req |=> !flash_cmd.req)
    else $error("request longer than one cycle");
  stall_hold_a: assert property (cpu_stall && !flash_done && !$rose(cpu_stall) |=> cpu_stall)
    else $error("stall dropped early");
  done_release_a: assert property (cpu_stall && flash_done |=> !cpu_stall)
    else $error("stall kept after done");
  refuse_short_a: assert property ($rose(cpu_stall) && !flash_cmd.req |=> !cpu_stall)
    else $error("refused stall too long");
  read_cause_a: assert property (flash_cmd.req && flash_cmd.op == OP_READ |-> $past(cw && sfr.wdata[BIT_READ]))
    else $error("read without initiate");
  write_cause_a: assert property (flash_cmd.req && flash_cmd.op == OP_WRITE |-> $past(cw && sfr.wdata[BIT_WRITE]))
    else $error("write without initiate");
  cover property (flash_cmd.req && flash_cmd.op == OP_READ);
  cover property (flash_cmd.req && flash_cmd.op == OP_ERASE);
  cover property ($rose(cpu_stall) && !flash_cmd.req);
endmodule

bind flash_iap_control flash_ctl_checker #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) chk_i (.mclk(mclk), .reset(reset),
  .sfr(sfr), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd), .flash_done(flash_done),
  .flash_rdata(flash_rdata), .buffer_load(buffer_load), .buffer_word(buffer_word));

/* test/iap_flash_control_register_tb.sv */
/*
  Self-checking bench for the flash control block.
  Plays both the CPU and the flash array; the timer is shortened by parameter.
*/
`timescale 1ns/1ps
module iap_flash_control_register_tb;
  import flash_ctl_pkg::*;
  localparam int UC = 40;
  logic mclk = 0, reset = 1, flash_done = 0, buffer_load, cpu_stall;
  logic [7:0] sfr_rdata, r = 8'h57;
  logic [15:0] flash_rdata = '0, buffer_word;
  logic [7:0] pat[6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  sfr_req_t sfr = '0;
  flash_cmd_t flash_cmd;
  int errors = 0, tests_run = 0, m[16], rsv[4] = '{2, 4, 5, 7};
  flash_iap_control #(.UNLOCK_CYCLES(16'(UC))) dut (.mclk(mclk), .reset(reset), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .cpu_stall(cpu_stall), .flash_cmd(flash_cmd), .flash_done(flash_done), .flash_rdata(flash_rdata),
    .buffer_load(buffer_load), .buffer_word(buffer_word));
  always #20 mclk = ~mclk;
  function automatic logic [7:0] nx(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(logic [3:0] s, logic [7:0] d);
    int a;
    @(posedge mclk) sfr <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(posedge mclk) sfr <= '0;
    if (s < SEL_CTRL) m[s] = d;
    a = (m[1] * 256 + m[0] + 1) % 32768;
    if (s == SEL_DATA0_HIGH) {m[1], m[0]} = {a / 256, a % 256};
  endtask
  task automatic rd(logic [3:0] s, logic [7:0] e);
    @(posedge mclk) sfr <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
    @(posedge mclk) sfr <= '0;
    @(negedge mclk) chk("sfr_rdata", 16'(e), 16'(sfr_rdata));
  endtask
  // A refused initiate still stalls for exactly one cycle, so both paths check the stall.
  task automatic op(logic [7:0] c, logic go, flash_op_t o);
    wr(SEL_CTRL, c);
    @(negedge mclk) chk("cpu_stall", 16'h0001, 16'(cpu_stall));
    chk("req", 16'(go), 16'(flash_cmd.req));
    if (go) begin
      chk("op", 16'(o), 16'(flash_cmd.op));
      if (o == OP_WRITE) chk("addr", 16'(m[1] * 256 + m[0]), 16'(flash_cmd.addr));
      r = nx(r);
      repeat (3) @(posedge mclk);
      flash_done <= 1'b1;
      flash_rdata <= {r, ~r};
      @(posedge mclk) flash_done <= 1'b0;
      if (o == OP_READ) {m[3], m[2]} = {32'(r), 32'(~r)};
    end
    @(posedge mclk);
    @(negedge mclk) chk("cpu_stall", 16'h0000, 16'(cpu_stall));
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(SEL_CTRL, 8'h00);
    rd(SEL_DATA_LAST, 8'h00);
    wr(SEL_DATA_LAST, r);
    rd(SEL_DATA_LAST, r);
    wr(SEL_CTRL, 8'h80);
    rd(SEL_CTRL, 8'h00);
    wr(SEL_ADDR_LOW, 8'hff);
    r = nx(r);
    wr(SEL_DATA_FIRST, r);
    wr(SEL_DATA0_HIGH, ~r);
    @(negedge mclk) chk("buffer_load", 16'h0001, 16'(buffer_load));
    chk("buffer_word", {~r, r}, buffer_word);
    for (int s = 0; s < 4; s++) rd(4'(s), 8'(m[s]));
    for (int k = 0; k < 2; k++) begin
      wr(SEL_CTRL, 8'h68);
      foreach (pat[i]) wr(4'(i + 4), pat[i] ^ 8'(1 - k));
      rd(SEL_CTRL, 8'h68);
      repeat (UC) @(posedge mclk);
      rd(SEL_CTRL, k ? 8'he0 : 8'h60);
    end
    op(8'h84, 1'b1, OP_WRITE);
    op(8'h94, 1'b1, OP_ERASE);
    op(8'hb1, 1'b0, OP_READ);
    wr(SEL_CTRL, 8'hb2);
    op(8'hb3, 1'b1, OP_READ);
    rd(SEL_DATA_FIRST, 8'(m[2]));
    rd(SEL_DATA0_HIGH, 8'(m[3]));
    foreach (rsv[i]) begin
      op(8'h84 | 8'(rsv[i] << 4), 1'b0, OP_WRITE);
      rd(SEL_CTRL, 8'h80 | 8'(rsv[i] << 4));
    end
    wr(SEL_CTRL, 8'h00);
    rd(SEL_CTRL, 8'h00);
    op(8'h04, 1'b0, OP_WRITE);
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    stop_test;
  end
endmodule
